// ---- core/fpuc_ctrl.sv ----
// Function
// - erase clears a whole 512-byte page at least
// - each page is eight rows of sixty-four bytes
// - sectors are 1024 bytes for 8 kB, 512 bytes otherwise
// - at most eight sectors, never smaller than a page
// - first two program bytes hold option bits
// - information area sits at FE00h to FFFFh apart from program memory
// - timing comes from 16-bit kHz value in two byte registers
// - write-protect option 0 blocks user program and erase, debug mass erase allowed
// - write-protect option 1 allows program and erase subject to others
// - reset leaves the controller locked
// - page select rewrite must match, else relock; match activates page
// - 95h erases active page only in unprotected sector, any sector from debugger
// - any other command after unlock relocks and drops active page
// - mass erase only through the debug port
// - unlocked page accepts byte writes until next command write
// - sector protection clears to zero on reset
// - 5Eh maps page-select address to sector protection; else back
// - user writes to sector protection only set bits
// - protected sector blocks CPU writes and erases, not debugger
// - programming only clears bits; erased byte reads FFh
// - page erase completion relocks the controller
// - mass erase starts on 63h as third command from debugger
//
// Purpose: flash program and erase guard with unlock sequence
// Assumes: one register write per cycle; flash array outside
// Notes: flash array is driven through addr, data and strobes
`default_nettype none
module fpuc_ctrl
#(
    parameter int PAGES = 16,
    parameter int PAGE_ERASE_US = fpuc_pkg::PAGE_ERASE_TIME_US,
    parameter int MASS_ERASE_US = fpuc_pkg::MASS_ERASE_TIME_US
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [11:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic fromDebug,
    input wire logic write_protect_option,
    input wire logic progReq,
    input wire logic [15:0] progAddr,
    input wire logic [7:0] progData,
    input wire logic [7:0] flashRdData,
    output logic progDone,
    output logic progRefused,
    output logic busy,
    output logic flashProg,
    output logic flashPageErase,
    output logic flashMassErase,
    output logic [15:0] flashAddr,
    output logic [7:0] flashWrData
);
    import fpuc_pkg::*;
    // page offset width follows the row layout
    localparam int PAGE_BITS = $clog2(ROWS_PER_PAGE * ROW_BYTES);
    localparam logic [15:0] MEM_LAST = 16'(PAGES * PAGE_BYTES - 1);

    fpuc_state_e state_ff;
    fpuc_op_e op_ff;
    logic [7:0] page_ff;
    logic [7:0] sect_ff;
    logic sectSel_ff;
    logic [15:0] freq_ff;
    logic [17:0] usLeft_ff;
    logic [15:0] addr_ff;
    logic [7:0] data_ff;
    logic done_ff;
    logic refused_ff;
    logic usTick;
    logic pageProt;
    logic cmdWr;
    logic pageWr;
    logic inPage;
    logic inInfo;
    logic inOption;
    logic userOk;
    logic progOk;

    assign cmdWr = regWrEn && (regAddr == ADDR_CMD);
    assign pageWr = regWrEn && (regAddr == ADDR_PAGE);
    assign busy = (state_ff == ST_BUSY);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    fpuc_usec_tick u_tick (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .run(busy),
        .freqKhz(freq_ff),
        .usTick(usTick)
    );
    fpuc_sector_map #(.PAGES(PAGES)) u_map (
        .page(page_ff[3:0]),
        .sectMask(sect_ff),
        .protectedPage(pageProt)
    );

    // ----------------------------------------
    // program request qualification
    // ----------------------------------------
    // info area is outside program memory and outside page decode
    assign inInfo = (progAddr >= INFO_BASE) && (progAddr <= INFO_LAST);
    assign inOption = (progAddr < 16'(OPTION_BYTES));
    assign inPage = (progAddr[15:PAGE_BITS] == page_ff[15-PAGE_BITS:0]);
    // debugger ignores write protect and sector protect
    assign userOk = write_protect_option && !pageProt && inPage;
    assign progOk = !inInfo && (progAddr <= MEM_LAST) && !inOption
        && (fromDebug || userOk);

    // ----------------------------------------
    // frequency registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            freq_ff <= FREQ_RESET;
        else if (regWrEn && regAddr == ADDR_FREQ_HI)
            freq_ff[15:8] <= regWrData;
        else if (regWrEn && regAddr == ADDR_FREQ_LO)
            freq_ff[7:0] <= regWrData;
    end

    // ----------------------------------------
    // sector protection and its window
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            sectSel_ff <= 1'b0;
        else if (cmdWr)
            sectSel_ff <= (regWrData == CMD_SECT_SEL);
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            sect_ff <= SECT_RESET;
        else if (pageWr && sectSel_ff)
        begin
            // debugger may also clear bits
            if (fromDebug)
                sect_ff <= regWrData;
            else
                sect_ff <= sect_ff | regWrData;
        end
    end

    // ----------------------------------------
    // page select
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            page_ff <= 8'h00;
        else if (pageWr && !sectSel_ff && (state_ff == ST_LOCKED || fromDebug))
            page_ff <= regWrData;
    end

    // ----------------------------------------
    // unlock sequence and operation control
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_LOCKED;
            op_ff <= OP_PROG;
            usLeft_ff <= 18'h00000;
            addr_ff <= 16'h0000;
            data_ff <= ERASED_BYTE;
            done_ff <= 1'b0;
            refused_ff <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            refused_ff <= 1'b0;
            unique case (state_ff)
                ST_LOCKED:
                    if (cmdWr && regWrData == CMD_UNLOCK1)
                        state_ff <= ST_UNLOCK1;
                    else if (progReq)
                        refused_ff <= 1'b1;
                ST_UNLOCK1:
                    if (cmdWr)
                        state_ff <= (regWrData == CMD_UNLOCK2) ? ST_UNLOCK2 : ST_LOCKED;
                    else if (progReq)
                        refused_ff <= 1'b1;
                ST_UNLOCK2:
                    if (pageWr && !sectSel_ff)
                        state_ff <= (regWrData == page_ff) ? ST_ACTIVE : ST_LOCKED;
                    else if (cmdWr && regWrData == CMD_MASS_ERASE && fromDebug)
                    begin
                        // debugger skips the page rewrite, so 63h is its third command
                        state_ff <= ST_BUSY;
                        op_ff <= OP_MASS;
                        usLeft_ff <= 18'(MASS_ERASE_US);
                    end
                    else if (cmdWr)
                        state_ff <= ST_LOCKED;
                    else if (progReq && fromDebug && progOk)
                    begin
                        // debugger may program straight after the unlock codes
                        state_ff <= ST_BUSY;
                        op_ff <= OP_PROG;
                        addr_ff <= progAddr;
                        data_ff <= progData & flashRdData;
                        usLeft_ff <= 18'(PROG_TIME_US);
                    end
                    else if (progReq)
                        refused_ff <= 1'b1;
                ST_ACTIVE:
                    if (cmdWr && regWrData == CMD_PAGE_ERASE && !pageProt
                        && write_protect_option)
                    begin
                        // sector check waived for the debugger
                        state_ff <= ST_BUSY;
                        op_ff <= OP_PAGE;
                        usLeft_ff <= 18'(PAGE_ERASE_US);
                    end
                    else if (cmdWr && regWrData == CMD_PAGE_ERASE && fromDebug)
                    begin
                        state_ff <= ST_BUSY;
                        op_ff <= OP_PAGE;
                        usLeft_ff <= 18'(PAGE_ERASE_US);
                    end
                    else if (cmdWr && regWrData == CMD_MASS_ERASE && fromDebug)
                    begin
                        state_ff <= ST_BUSY;
                        op_ff <= OP_MASS;
                        usLeft_ff <= 18'(MASS_ERASE_US);
                    end
                    else if (cmdWr)
                        state_ff <= ST_LOCKED;
                    else if (progReq && progOk)
                    begin
                        // page stays open after a byte write
                        state_ff <= ST_BUSY;
                        op_ff <= OP_PROG;
                        addr_ff <= progAddr;
                        data_ff <= progData & flashRdData;
                        usLeft_ff <= 18'(PROG_TIME_US);
                    end
                    else if (progReq)
                        refused_ff <= 1'b1;
                ST_BUSY:
                    if (usTick)
                    begin
                        if (usLeft_ff <= 18'h00001)
                        begin
                            done_ff <= 1'b1;
                            // erase relocks, programming keeps the page
                            state_ff <= (op_ff == OP_PROG) ? ST_ACTIVE : ST_LOCKED;
                        end
                        usLeft_ff <= usLeft_ff - 18'h00001;
                    end
                default:
                    state_ff <= ST_LOCKED;
            endcase
        end
    end

    // ----------------------------------------
    // flash array drive
    // ----------------------------------------
    // page erase addresses all eight rows of the page at once
    assign flashProg = busy && (op_ff == OP_PROG);
    assign flashPageErase = busy && (op_ff == OP_PAGE);
    assign flashMassErase = busy && (op_ff == OP_MASS);
    assign flashAddr = (op_ff == OP_PROG) ? addr_ff
        : {page_ff[15-PAGE_BITS:0], {PAGE_BITS{1'b0}}};
    assign flashWrData = data_ff;
    assign progDone = done_ff;
    assign progRefused = refused_ff;

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always_comb
    begin
        regRdData = 8'h00;
        if (regRdEn)
        begin
            unique case (regAddr)
                ADDR_CMD: regRdData = {5'h00, state_ff};
                ADDR_PAGE: regRdData = sectSel_ff ? sect_ff : page_ff;
                ADDR_FREQ_HI: regRdData = freq_ff[15:8];
                ADDR_FREQ_LO: regRdData = freq_ff[7:0];
                default: regRdData = 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- core/fpuc_pkg.sv ----
// Purpose: shared constants for the flash protect and unlock controller
// Assumes: byte-wide register file, 100 MHz system clock
// Notes: offsets are register file addresses
`default_nettype none
package fpuc_pkg;
    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [11:0] ADDR_CMD = 12'hff8;
    localparam logic [11:0] ADDR_PAGE = 12'hff9;
    localparam logic [11:0] ADDR_FREQ_HI = 12'hffa;
    localparam logic [11:0] ADDR_FREQ_LO = 12'hffb;
    // ----------------------------------------
    // command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
    localparam logic [7:0] CMD_SECT_SEL = 8'h5e;
    // ----------------------------------------
    // geometry and reset values
    // ----------------------------------------
    localparam int PAGE_BYTES = 512;
    localparam int ROWS_PER_PAGE = 8;
    localparam int ROW_BYTES = 64;
    localparam int MAX_SECTORS = 8;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] SECT_RESET = 8'h00;
    localparam logic [15:0] FREQ_RESET = 16'h0000;
    localparam logic [15:0] INFO_BASE = 16'hfe00;
    localparam logic [15:0] INFO_LAST = 16'hffff;
    localparam int OPTION_BYTES = 2;
    // ----------------------------------------
    // timing: pulse lengths in microseconds
    // ----------------------------------------
    localparam int PROG_TIME_US = 40;
    localparam int PAGE_ERASE_TIME_US = 10000;
    localparam int MASS_ERASE_TIME_US = 200000;
    // ----------------------------------------
    // controller states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_LOCKED = 3'b000,
        ST_UNLOCK1 = 3'b001,
        ST_UNLOCK2 = 3'b010,
        ST_ACTIVE = 3'b011,
        ST_BUSY = 3'b100
    } fpuc_state_e;
    typedef enum logic [1:0] {
        OP_PROG = 2'b00,
        OP_PAGE = 2'b01,
        OP_MASS = 2'b10
    } fpuc_op_e;
endpackage
`default_nettype wire

// ---- core/fpuc_sector_map.sv ----
// Purpose: maps a page number onto its protection sector bit
// Assumes: PAGES is a power of two, at most 16
// Notes: sector is an eighth of the flash, never below one page
`default_nettype none
module fpuc_sector_map
#(
    parameter int PAGES = 16
)
(
    input wire logic [3:0] page,
    input wire logic [7:0] sectMask,
    output logic protectedPage
);
    import fpuc_pkg::*;
    localparam int PPS = (PAGES > MAX_SECTORS) ? PAGES / MAX_SECTORS : 1;
    logic [3:0] sectIdx;
    // 8 kB: two pages per 1024-byte sector, else one page each
    assign sectIdx = page / 4'(PPS);
    assign protectedPage = sectMask[sectIdx[2:0]];
endmodule
`default_nettype wire

// ---- core/fpuc_usec_tick.sv ----
// Purpose: one-microsecond enable pulse from the kHz frequency value
// Assumes: freqKhz holds the system clock in kHz
// Notes: a microsecond is freqKhz/1000 cycles; at least one cycle
`default_nettype none
module fpuc_usec_tick
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [15:0] freqKhz,
    output logic usTick
);
    import fpuc_pkg::*;
    logic [15:0] cnt_ff;
    logic [15:0] reload;
    // round up so no pulse is shortened while freqKhz + 999 still fits in 16 bits
    assign reload = (freqKhz + 16'd999) / 16'd1000;
    assign usTick = run && (cnt_ff + 16'h0001 >= reload);
    // ----------------------------------------
    // cycle counter scaled by frequency
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            cnt_ff <= 16'h0000;
        else if (!run || usTick)
            cnt_ff <= 16'h0000;
        else
            cnt_ff <= cnt_ff + 16'h0001;
    end
endmodule
`default_nettype wire

// ---- tb/flash_protect_unlock_ctrl_tb.sv ----
// Purpose: self-checking bench for fpuc_ctrl
// Assumes: 100 MHz clock, clock value 2000 kHz
// Notes: short erase parameters keep the run small
`default_nettype none
module flash_protect_unlock_ctrl_tb
import fpuc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // bench
    // ----
    logic ref_clk = 0, nrst = 0, regWrEn = 0, regRdEn = 0, fromDebug = 0, progReq = 0;
    logic write_protect_option = 1;
    logic [11:0] regAddr = 0;
    logic [7:0] regWrData = 0, progData = 0;
    logic [15:0] progAddr = 0;
    wire logic [7:0] regRdData, flashRdData, flashWrData;
    wire logic progDone, progRefused, busy, flashProg, flashPageErase, flashMassErase;
    wire logic [15:0] flashAddr;
    int errors = 0, checks_done = 0;
    always #5 ref_clk = ~ref_clk;
    fpuc_ctrl #(.PAGES(16), .PAGE_ERASE_US(3), .MASS_ERASE_US(3)) dut (.ref_clk, .nrst,
        .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .fromDebug,
        .write_protect_option, .progReq, .progAddr, .progData, .flashRdData, .progDone,
        .progRefused, .busy, .flashProg, .flashPageErase, .flashMassErase, .flashAddr,
        .flashWrData);
    fpuc_flash_model flash (.ref_clk, .flashProg, .flashPageErase, .flashMassErase,
        .flashAddr, .flashWrData, .progAddr, .flashRdData);
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(negedge ref_clk);
        chk(regRdData, exp);
        @(posedge ref_clk);
        regRdEn <= 1'b0;
    endtask
    // page, two codes, same page again; 00 first clears any half sequence
    task automatic unlock(input logic [7:0] p);
        wr(ADDR_CMD, 8'h00);
        wr(ADDR_PAGE, p);
        wr(ADDR_CMD, CMD_UNLOCK1);
        wr(ADDR_CMD, CMD_UNLOCK2);
        wr(ADDR_PAGE, p);
    endtask
    task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic refuse);
        int n;
        n = 0;
        @(posedge ref_clk);
        progAddr <= a;
        progData <= d;
        progReq <= 1'b1;
        @(posedge ref_clk);
        progReq <= 1'b0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (progDone !== 1'b1 && progRefused !== 1'b1 && n < 400);
        if (n >= 400)
        begin
            errors++;
            $display("Error at %0t: program timeout", $time);
            tally_and_finish();
        end
        chk({7'h00, progRefused}, {7'h00, refuse});
    endtask
    task automatic cmd_op(input logic [7:0] c, input logic expBusy);
        logic saw;
        saw = 0;
        wr(ADDR_CMD, c);
        for (int n = 0; n < 40 && progDone !== 1'b1; n++)
        begin
            @(negedge ref_clk);
            saw |= (busy === 1'b1);
        end
        chk({7'h00, saw}, {7'h00, expBusy});
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(ADDR_CMD, {5'h00, ST_LOCKED});
        wr(ADDR_FREQ_HI, 8'h07);
        wr(ADDR_FREQ_LO, 8'hd0);
        prog(16'h0405, 8'h0f, 1'b1);
        unlock(8'h02);
        rd(ADDR_CMD, {5'h00, ST_ACTIVE});
        prog(16'h0405, 8'h0f, 1'b0);
        prog(16'h0406, 8'h3c, 1'b0);
        prog(16'h0405, 8'hf0, 1'b0);
        prog(16'h0600, 8'h00, 1'b1);
        chk(flash.mem[13'h0405], 8'h00);
        wr(ADDR_CMD, 8'h00);
        rd(ADDR_CMD, {5'h00, ST_LOCKED});
        prog(16'h0407, 8'h00, 1'b1);
        wr(ADDR_PAGE, 8'h02);
        wr(ADDR_CMD, CMD_UNLOCK1);
        wr(ADDR_CMD, CMD_UNLOCK2);
        wr(ADDR_PAGE, 8'h03);
        rd(ADDR_CMD, {5'h00, ST_LOCKED});
        unlock(8'h02);
        cmd_op(CMD_PAGE_ERASE, 1'b1);
        rd(ADDR_CMD, {5'h00, ST_LOCKED});
        chk(flash.mem[13'h0406], ERASED_BYTE);
        unlock(8'h00);
        prog(16'h0001, 8'h00, 1'b1);
        wr(ADDR_CMD, 8'h00);
        wr(ADDR_CMD, CMD_SECT_SEL);
        wr(ADDR_PAGE, 8'h02);
        wr(ADDR_PAGE, 8'h00);
        rd(ADDR_PAGE, 8'h02);
        wr(ADDR_CMD, 8'h00);
        rd(ADDR_PAGE, 8'h00);
        unlock(8'h02);
        prog(16'h0405, 8'h00, 1'b1);
        unlock(8'h02);
        cmd_op(CMD_PAGE_ERASE, 1'b0);
        unlock(8'h06);
        prog(16'h0c01, 8'h55, 1'b0);
        @(posedge ref_clk);
        write_protect_option <= 1'b0;
        unlock(8'h04);
        prog(16'h0805, 8'h00, 1'b1);
        unlock(8'h04);
        cmd_op(CMD_PAGE_ERASE, 1'b0);
        unlock(8'h04);
        cmd_op(CMD_MASS_ERASE, 1'b0);
        @(posedge ref_clk);
        fromDebug <= 1'b1;
        wr(ADDR_CMD, 8'h00);
        wr(ADDR_PAGE, 8'h04);
        wr(ADDR_CMD, CMD_UNLOCK1);
        wr(ADDR_CMD, CMD_UNLOCK2);
        cmd_op(CMD_MASS_ERASE, 1'b1);
        chk(flash.mem[13'h0c01], ERASED_BYTE);
        wr(ADDR_CMD, 8'h00);
        wr(ADDR_PAGE, 8'h04);
        wr(ADDR_CMD, CMD_UNLOCK1);
        wr(ADDR_CMD, CMD_UNLOCK2);
        prog(16'hfe10, 8'h00, 1'b1);
        prog(16'h0410, 8'h00, 1'b0);
        chk(flash.mem[13'h0410], 8'h00);
        @(posedge ref_clk);
        fromDebug <= 1'b0;
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        wr(ADDR_CMD, CMD_SECT_SEL);
        rd(ADDR_PAGE, SECT_RESET);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- tb/fpuc_ctrl_checker.sv ----
// Purpose: port checks for fpuc_ctrl
// Assumes: one clock, async active-low reset
// Notes: bound to every fpuc_ctrl instance
`default_nettype none
module fpuc_ctrl_checker
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic fromDebug,
    input wire logic write_protect_option,
    input wire logic progReq,
    input wire logic [7:0] progData,
    input wire logic [7:0] flashRdData,
    input wire logic progDone,
    input wire logic progRefused,
    input wire logic busy,
    input wire logic flashProg,
    input wire logic flashPageErase,
    input wire logic flashMassErase,
    input wire logic [15:0] flashAddr,
    input wire logic [7:0] flashWrData
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_strobe_busy;
        busy |-> $onehot({flashProg, flashPageErase, flashMassErase});
    endproperty
    a_strobe_busy: assert property (p_strobe_busy) else $error("bad strobe");
    property p_mass_dbg;
        $rose(flashMassErase) |-> $past(fromDebug);
    endproperty
    a_mass_dbg: assert property (p_mass_dbg) else $error("user mass erase");
    property p_page_wp;
        $rose(flashPageErase) |-> $past(write_protect_option) || $past(fromDebug);
    endproperty
    a_page_wp: assert property (p_page_wp) else $error("erase under wp");
    property p_prog_wp;
        progReq && !busy && !write_protect_option && !fromDebug |=> progRefused;
    endproperty
    a_prog_wp: assert property (p_prog_wp) else $error("prog under wp");
    // and with current content: bits only go to zero
    property p_prog_and;
        $rose(flashProg) |-> flashWrData == ($past(progData) & $past(flashRdData));
    endproperty
    a_prog_and: assert property (p_prog_and) else $error("bit set by prog");
    property p_done_fall;
        $fell(busy) |-> progDone || $past(progDone);
    endproperty
    a_done_fall: assert property (p_done_fall) else $error("no done");
    property p_erase_len;
        $rose(flashPageErase) |=> flashPageErase [*2];
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase short");
    property p_page_base;
        flashPageErase |-> flashAddr[8:0] == 9'h000;
    endproperty
    a_page_base: assert property (p_page_base) else $error("erase not page");
endmodule
bind fpuc_ctrl fpuc_ctrl_checker chk_i (.ref_clk, .nrst, .fromDebug, .write_protect_option,
    .progReq, .progData, .flashRdData, .progDone, .progRefused, .busy, .flashProg,
    .flashPageErase, .flashMassErase, .flashAddr, .flashWrData);
`default_nettype wire

// ---- tb/fpuc_flash_model.sv ----
// Purpose: byte array behind the controller
// Assumes: 8 kB, erased bytes read ff
// Notes: read is combinational on progAddr
`default_nettype none
module fpuc_flash_model
(
    input wire logic ref_clk,
    input wire logic flashProg,
    input wire logic flashPageErase,
    input wire logic flashMassErase,
    input wire logic [15:0] flashAddr,
    input wire logic [7:0] flashWrData,
    input wire logic [15:0] progAddr,
    output logic [7:0] flashRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // array
    // ----
    logic [7:0] mem [0:8191];
    initial foreach (mem[i]) mem[i] = 8'hff;
    assign flashRdData = mem[progAddr[12:0]];
    always @(posedge ref_clk)
    begin
        if (flashProg)
            mem[flashAddr[12:0]] <= flashWrData;
        if (flashPageErase)
            for (int i = 0; i < 512; i++)
                mem[{flashAddr[12:9], 9'(i)}] <= 8'hff;
        if (flashMassErase)
            foreach (mem[i]) mem[i] <= 8'hff;
    end
endmodule
`default_nettype wire
